// ### aoc_defs.svh
`ifndef AOC_DEFS_SVH
`define AOC_DEFS_SVH

// register byte offsets
`define AOC_REQ_OFS        12'h000
`define AOC_ECHO_OFS       12'h004
`define AOC_STATUS_OFS     12'h008
`define AOC_CTRL_OFS       12'h00C
`define AOC_SLEW_OFS       12'h010
`define AOC_LOW_OFS        12'h014
`define AOC_HIGH_OFS       12'h018
`define AOC_PROG_OFS       12'h01C
`define AOC_FAULT_OFS      12'h020
`define AOC_FS_OFS         12'h024
`define AOC_IRQ_STAT_OFS   12'h028
`define AOC_IRQ_CLR_OFS    12'h02C
`define AOC_IRQ_EN_OFS     12'h030

// control register bit positions
`define AOC_CTRL_RUN       0
`define AOC_CTRL_CAL       1
`define AOC_CTRL_HOLD_EN   2
`define AOC_CTRL_RAMP_EN   3
`define AOC_CTRL_SLEW_LAT  4
`define AOC_CTRL_CLAMP_LAT 5
`define AOC_CTRL_PFE       6
`define AOC_CTRL_UNL_RAMP  8
`define AOC_CTRL_UNL_CLAMP 9
`define AOC_CTRL_W         7

// flag count, same layout in status, irq status, clear and enable
`define AOC_FLAG_W         6

// reset values, ieee single precision
`define AOC_REQ_RST        32'h00000000
`define AOC_SLEW_RST       32'h3F800000
`define AOC_LOW_RST        32'hC1200000
`define AOC_HIGH_RST       32'h41200000
`define AOC_PROG_RST       32'h00000000
`define AOC_FAULT_RST      32'h00000000
`define AOC_FS_RST         32'h41A00000

// float format and internal fixed point
`define AOC_FLT_BIAS       127
`define AOC_FLT_MANT       23
`define AOC_Q_FRAC         16

// timing
`define AOC_CLK_PERIOD_NS  10
`define AOC_RAMP_TICK_NS   1000
`define AOC_RAMP_TICK_CYC  (`AOC_RAMP_TICK_NS / `AOC_CLK_PERIOD_NS)
`define AOC_HOLD_TOL_DIV   32'd1000

`endif

// ### aoc_pkg.sv
package aoc_pkg;

   typedef enum logic [1:0] {AOC_PROG, AOC_HOLD, AOC_RUN} aoc_mode_e;

   typedef struct packed {
      logic pfe;
      logic clamp_alarm_latch_enable;
      logic slew_alarm_latch_enable;
      logic ramp_on_run_enable;
      logic hold_enable;
      logic calibrate;
      logic run_mode;
   } aoc_ctrl_s;

   typedef struct packed {
      logic any_channel_fault_flag;
      logic output_hold_flag;
      logic high_clamp_alarm;
      logic low_clamp_alarm;
      logic ramp_rate_alarm;
      logic invalid_float_flag;
   } aoc_flags_s;

endpackage

// ### aoc_channel.sv
// What this block does
// - the echo shows the value really driven, so it differs from the request in program mode, calibration, clamping, ramping and hold.
// - the group fault flag is high while any channel fault is present.
// - the invalid flag is set when a request is not a valid ieee float.
// - an invalid request is dropped and the last valid request keeps driving.
// - in hold the output stays frozen and the hold flag stays up until request and output agree within 0.1% of full scale.
// - with ramp enabled a step larger than the slew setting raises the ramp alarm.
// - the ramp alarm follows ramping, or stays set when its latch is enabled.
// - a request under the low clamp raises the low alarm and drives the low clamp value.
// - the low alarm clears once the request is back above the clamp unless latched.
// - a request over the high clamp raises the high alarm and drives the high clamp value.
// - the high alarm clears once the request is back below the clamp unless latched.
// - in program mode with the fault enable set a comm fault drives the fault value.
// - in program mode with the fault enable clear a comm fault keeps the program value.
//
// Design decisions made here: the register offsets and the APB slave port.
`include "aoc_defs.svh"

module aoc_channel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comm_fault_in,
   output logic signed [31:0] driven_value,
   output logic [31:0] driven_value_echo,
   output aoc_pkg::aoc_flags_s channel_flags,
   output logic irq
);
   import aoc_pkg::*;

   function automatic logic signed [31:0] aoc_f2q(input logic [31:0] f);
      logic [7:0] e;
      logic [7:0] unit;
      logic [31:0] mag;
      e = f[30:23];
      unit = 8'(`AOC_FLT_BIAS + `AOC_FLT_MANT - `AOC_Q_FRAC);
      mag = 32'h00000000;
      // saturate rather than wrap, a wrapped value would swing the output
      if (e >= 8'(unit + 8'h08))
         mag = 32'h7FFFFFFF;
      else if (e >= unit)
         mag = {8'h00, 1'b1, f[22:0]} << (e - unit);
      else if (e != 8'h00)
         mag = {8'h00, 1'b1, f[22:0]} >> (unit - e);
      return f[31] ? -$signed(mag) : $signed(mag);
   endfunction

   function automatic logic [31:0] aoc_q2f(input logic signed [31:0] q);
      logic [31:0] a;
      logic [31:0] m;
      logic [7:0] e;
      int p;
      a = q[31] ? 32'(-q) : 32'(q);
      p = 0;
      for (int i = 0; i < 32; i++) begin
         if (a[i])
            p = i;
      end
      m = a << (31 - p);
      e = 8'(`AOC_FLT_BIAS + p - `AOC_Q_FRAC);
      return (a == 32'h00000000) ? 32'h00000000 : {q[31], e, m[30:8]};
   endfunction

   function automatic logic aoc_mapped(input logic [11:0] a);
      return a <= `AOC_IRQ_EN_OFS && a[1:0] == 2'b00;
   endfunction

   function automatic logic aoc_bad_float(input logic [31:0] f);
      return f[30:23] == 8'hFF;
   endfunction

   // registers
   logic [31:0] req_valid, slew_f, low_f, high_f, prog_f, fault_f, fs_f;
   aoc_ctrl_s ctrl;
   logic [`AOC_FLAG_W-1:0] irq_status;
   logic [`AOC_FLAG_W-1:0] irq_enable;
   logic [`AOC_FLAG_W-1:0] flags_prev;
   aoc_mode_e mode;
   aoc_mode_e next_mode;
   logic [1:0] cf_sync;
   logic [15:0] tick_cnt;
   logic tick;

   // apb decode, zero wait states
   logic access, wr, req_wr, ctrl_wr, unl_ramp, unl_clamp;
   logic [31:0] rd_value;

   assign access = psel & penable;
   assign pready = 1'b1;
   assign pslverr = access & ~aoc_mapped(paddr);
   assign wr = access & pwrite & aoc_mapped(paddr);
   assign req_wr = wr && paddr == `AOC_REQ_OFS;
   assign ctrl_wr = wr && paddr == `AOC_CTRL_OFS;
   assign unl_ramp = ctrl_wr & pwdata[`AOC_CTRL_UNL_RAMP];
   assign unl_clamp = ctrl_wr & pwdata[`AOC_CTRL_UNL_CLAMP];

   always_comb begin
      rd_value = 32'h00000000;
      unique case (paddr)
         `AOC_REQ_OFS: rd_value = req_valid;
         `AOC_ECHO_OFS: rd_value = driven_value_echo;
         `AOC_STATUS_OFS: rd_value = 32'(channel_flags);
         `AOC_CTRL_OFS: rd_value = 32'(ctrl);
         `AOC_SLEW_OFS: rd_value = slew_f;
         `AOC_LOW_OFS: rd_value = low_f;
         `AOC_HIGH_OFS: rd_value = high_f;
         `AOC_PROG_OFS: rd_value = prog_f;
         `AOC_FAULT_OFS: rd_value = fault_f;
         `AOC_FS_OFS: rd_value = fs_f;
         `AOC_IRQ_STAT_OFS: rd_value = 32'(irq_status);
         `AOC_IRQ_EN_OFS: rd_value = 32'(irq_enable);
         default: rd_value = 32'h00000000;
      endcase
   end

   // read data is captured in the setup cycle so it is a flop output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
         prdata <= rd_value;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_f <= `AOC_SLEW_RST;
         low_f <= `AOC_LOW_RST;
         high_f <= `AOC_HIGH_RST;
         prog_f <= `AOC_PROG_RST;
         fault_f <= `AOC_FAULT_RST;
         fs_f <= `AOC_FS_RST;
         ctrl <= '0;
         irq_enable <= '0;
      end else if (wr) begin
         unique case (paddr)
            `AOC_SLEW_OFS: slew_f <= pwdata;
            `AOC_LOW_OFS: low_f <= pwdata;
            `AOC_HIGH_OFS: high_f <= pwdata;
            `AOC_PROG_OFS: prog_f <= pwdata;
            `AOC_FAULT_OFS: fault_f <= pwdata;
            `AOC_FS_OFS: fs_f <= pwdata;
            `AOC_CTRL_OFS: ctrl <= aoc_ctrl_s'(pwdata[`AOC_CTRL_W-1:0]);
            `AOC_IRQ_EN_OFS: irq_enable <= pwdata[`AOC_FLAG_W-1:0];
            default: ;
         endcase
      end
   end

   // last valid request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         req_valid <= `AOC_REQ_RST;
      else if (req_wr && !aoc_bad_float(pwdata))
         req_valid <= pwdata;
   end

   // the comm fault pin is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cf_sync <= 2'b00;
      else
         cf_sync <= {cf_sync[0], comm_fault_in};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tick_cnt <= 16'h0000;
      else if (tick)
         tick_cnt <= 16'h0000;
      else
         tick_cnt <= tick_cnt + 16'h0001;
   end
   assign tick = tick_cnt == 16'(`AOC_RAMP_TICK_CYC - 1);

   // datapath in signed q16.16
   logic signed [31:0] req_q, low_q, high_q, slew_q, tol_q, target;
   logic signed [32:0] diff;
   logic [32:0] adiff;
   logic low_cond, high_cond, over_step, within_tol, cf, ramp_active;

   assign cf = cf_sync[1];
   assign req_q = aoc_f2q(req_valid);
   assign low_q = aoc_f2q(low_f);
   assign high_q = aoc_f2q(high_f);
   assign slew_q = aoc_f2q(slew_f);
   assign tol_q = aoc_f2q(fs_f) / $signed(`AOC_HOLD_TOL_DIV);
   assign low_cond = req_q < low_q;
   assign high_cond = req_q > high_q;
   assign target = low_cond ? low_q : (high_cond ? high_q : req_q);
   assign diff = {target[31], target} - {driven_value[31], driven_value};
   assign adiff = diff[32] ? 33'(-diff) : 33'(diff);
   assign over_step = ctrl.ramp_on_run_enable &&
                      adiff > 33'(slew_q);
   assign within_tol = adiff <= 33'(tol_q);
   assign ramp_active = mode == AOC_RUN && !ctrl.calibrate && !cf &&
                        over_step;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         AOC_PROG: if (ctrl.run_mode)
            next_mode = ctrl.hold_enable ? AOC_HOLD : AOC_RUN;
         AOC_HOLD: if (!ctrl.run_mode)
            next_mode = AOC_PROG;
         else if (within_tol)
            next_mode = AOC_RUN;
         AOC_RUN: if (!ctrl.run_mode)
            next_mode = AOC_PROG;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode <= AOC_PROG;
      else
         mode <= next_mode;
   end

   // driven output; calibration freezes it, the echo then shows the freeze
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         driven_value <= 32'sh00000000;
      else if (!ctrl.calibrate) begin
         unique case (mode)
            AOC_PROG: driven_value <= (cf && ctrl.pfe) ?
               aoc_f2q(fault_f) : aoc_f2q(prog_f);
            AOC_HOLD: driven_value <= driven_value;
            AOC_RUN: if (cf)
               driven_value <= aoc_f2q(fault_f);
            else if (!over_step)
               driven_value <= target;
            else if (tick)
               driven_value <= diff[32] ? driven_value - slew_q :
                               driven_value + slew_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         driven_value_echo <= 32'h00000000;
      else
         driven_value_echo <= aoc_q2f(driven_value);
   end

   // flags; a latch holds until unlatch, the condition term re-sets it
   logic flag_invalid, flag_ramp, flag_low, flag_high, flag_group;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_invalid <= 1'b0;
         flag_ramp <= 1'b0;
         flag_low <= 1'b0;
         flag_high <= 1'b0;
         flag_group <= 1'b0;
      end else begin
         if (req_wr)
            flag_invalid <= aoc_bad_float(pwdata);
         flag_ramp <= ramp_active |
            (ctrl.slew_alarm_latch_enable & flag_ramp & ~unl_ramp);
         flag_low <= low_cond |
            (ctrl.clamp_alarm_latch_enable & flag_low & ~unl_clamp);
         flag_high <= high_cond |
            (ctrl.clamp_alarm_latch_enable & flag_high & ~unl_clamp);
         flag_group <= flag_invalid | flag_ramp | flag_low |
            flag_high;
      end
   end
   // one driver for the whole struct; hold decodes the mode register
   assign channel_flags = {flag_group, mode == AOC_HOLD, flag_high,
                           flag_low, flag_ramp, flag_invalid};

   // sticky interrupt bits on each rising flag; set beats clear
   logic [`AOC_FLAG_W-1:0] flags_now;
   logic [`AOC_FLAG_W-1:0] clr;
   assign flags_now = channel_flags;
   assign clr = (wr && paddr == `AOC_IRQ_CLR_OFS) ?
                pwdata[`AOC_FLAG_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         flags_prev <= '0;
      else
         flags_prev <= flags_now;
   end

   for (genvar i = 0; i < `AOC_FLAG_W; i++) begin : g_irq
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn)
            irq_status[i] <= 1'b0;
         else if (flags_now[i] & ~flags_prev[i])
            irq_status[i] <= 1'b1;
         else if (clr[i])
            irq_status[i] <= 1'b0;
      end
   end
   assign irq = |(irq_status & irq_enable);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   invalid_sets_flag_a: assert property (
      req_wr && aoc_bad_float(pwdata) |=> channel_flags.invalid_float_flag)
      else $error("invalid request did not raise the flag");
   invalid_keeps_req_a: assert property (
      req_wr && aoc_bad_float(pwdata) |=> $stable(req_valid))
      else $error("invalid request replaced the last valid one");
   group_fault_a: assert property (
      channel_flags.low_clamp_alarm || channel_flags.high_clamp_alarm
      |=> channel_flags.any_channel_fault_flag)
      else $error("group fault missed a channel fault");
   hold_freeze_a: assert property (
      mode == AOC_HOLD && ctrl.run_mode && !within_tol
      |=> $stable(driven_value)
      && channel_flags.output_hold_flag)
      else $error("output moved while holding");
   low_clamp_a: assert property (
      mode == AOC_RUN && next_mode == AOC_RUN && !ctrl.calibrate && !cf
      && !over_step && low_cond |=> driven_value == $past(low_q))
      else $error("low clamp not driven");
   high_clamp_a: assert property (
      mode == AOC_RUN && next_mode == AOC_RUN && !ctrl.calibrate && !cf
      && !over_step && high_cond |=> driven_value == $past(high_q))
      else $error("high clamp not driven");
   low_unlatched_a: assert property (
      !ctrl.clamp_alarm_latch_enable && !low_cond
      |=> !channel_flags.low_clamp_alarm)
      else $error("unlatched low alarm did not clear");
   high_unlatched_a: assert property (
      !ctrl.clamp_alarm_latch_enable && !high_cond
      |=> !channel_flags.high_clamp_alarm)
      else $error("unlatched high alarm did not clear");
   ramp_alarm_a: assert property (
      ramp_active |=> channel_flags.ramp_rate_alarm)
      else $error("ramp alarm missing while ramping");
   ramp_latched_a: assert property (
      ctrl.slew_alarm_latch_enable && channel_flags.ramp_rate_alarm
      && !unl_ramp |=> channel_flags.ramp_rate_alarm)
      else $error("latched ramp alarm dropped");
   unlatch_needs_clear_a: assert property (
      unl_clamp && low_cond |=> channel_flags.low_clamp_alarm)
      else $error("unlatch cleared alarm with cause present");
   prog_fault_a: assert property (
      mode == AOC_PROG && !ctrl.calibrate && cf && ctrl.pfe
      |=> driven_value == aoc_f2q($past(fault_f)))
      else $error("program fault value not driven");
   prog_keep_a: assert property (
      mode == AOC_PROG && !ctrl.calibrate && cf && !ctrl.pfe
      |=> driven_value == aoc_f2q($past(prog_f)))
      else $error("program value not kept on comm fault");
   echo_follows_a: assert property (
      ctrl.calibrate [*2] |=> $stable(driven_value_echo))
      else $error("echo moved during calibration");

   hold_exit_c: cover property (mode == AOC_HOLD ##1 mode == AOC_RUN);
   ramp_done_c: cover property (ramp_active ##1 !ramp_active);
   low_alarm_c: cover property ($rose(channel_flags.low_clamp_alarm));
   irq_c: cover property ($rose(irq));

endmodule

// ### aoc_host.sv
// controller side: apb master plus the comm fault pin
`include "aoc_defs.svh"
module aoc_host (
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic comm_fault_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      comm_fault_in = 1'b0;
   end

   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines must not look like a held value
      pwdata <= ~d;
   endtask

   // unlatch pulses ride on a normal control write
   task automatic unlatch(input logic [31:0] ctrl, input logic [31:0] bits);
      logic [31:0] q;
      logic e;
      xfer(1'b1, `AOC_CTRL_OFS, ctrl | bits, q, e);
   endtask

   task automatic set_fault(input logic v);
      @(posedge pclk);
      comm_fault_in <= v;
   endtask
endmodule

// ### aoc_channel_test.sv
`include "aoc_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module aoc_channel_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cf;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, echo;
   logic signed [31:0] drv;
   aoc_pkg::aoc_flags_s flg;
   int n_fail = 0;
   int n_compared = 0;

   aoc_channel i_aoc_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comm_fault_in(cf), .driven_value(drv), .driven_value_echo(echo),
      .channel_flags(flg), .irq(irq));
   aoc_host i_aoc_host (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .comm_fault_in(cf));

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      i_aoc_host.xfer(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic e;
      i_aoc_host.xfer(1'b0, a, 32'h00000000, q, e);
      `CHK(nm, exp, q)
      `CHK("pslverr", err, e)
   endtask

   // request to echo takes three edges at worst, four leave a margin
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset;
      rd_chk("slew", `AOC_SLEW_OFS, 32'h3F800000, 1'b0);
      rd_chk("low", `AOC_LOW_OFS, 32'hC1200000, 1'b0);
      rd_chk("high", `AOC_HIGH_OFS, 32'h41200000, 1'b0);
      rd_chk("fs", `AOC_FS_OFS, 32'h41A00000, 1'b0);
      rd_chk("ctrl", `AOC_CTRL_OFS, 32'h00000000, 1'b0);
      rd_chk("unmapped", 12'h040, 32'h00000000, 1'b1);
      wr(`AOC_ECHO_OFS, 32'h12345678);
      rd_chk("echo ro", `AOC_ECHO_OFS, 32'h00000000, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_invalid;
      wr(`AOC_CTRL_OFS, 32'h00000001);
      wr(`AOC_IRQ_EN_OFS, 32'h00000002);
      wr(`AOC_REQ_OFS, 32'h40400000);
      settle(4);
      `CHK("echo run", 32'h40400000, echo)
      `CHK("driven", 32'h00030000, drv)
      wr(`AOC_REQ_OFS, 32'h7F800000);
      settle(4);
      `CHK("invalid", 1'b1, flg.invalid_float_flag)
      `CHK("group", 1'b1, flg.any_channel_fault_flag)
      `CHK("echo kept", 32'h40400000, echo)
      rd_chk("req kept", `AOC_REQ_OFS, 32'h40400000, 1'b0);
      rd_chk("irq stat", `AOC_IRQ_STAT_OFS, 32'h00000021, 1'b0);
      `CHK("irq masked", 1'b0, irq)
      wr(`AOC_IRQ_EN_OFS, 32'h00000021);
      settle(1);
      `CHK("irq on", 1'b1, irq)
      wr(`AOC_IRQ_CLR_OFS, 32'h0000003F);
      settle(1);
      `CHK("irq clr", 1'b0, irq)
      wr(`AOC_REQ_OFS, 32'h40400000);
      settle(4);
      `CHK("valid again", 1'b0, flg.invalid_float_flag)
      `CHK("group clr", 1'b0, flg.any_channel_fault_flag)
      $display("test invalid and irq done");
   endtask

   task automatic t_clamp;
      wr(`AOC_REQ_OFS, 32'h41A00000);
      settle(4);
      `CHK("high alarm", 1'b1, flg.high_clamp_alarm)
      `CHK("echo high", 32'h41200000, echo)
      wr(`AOC_REQ_OFS, 32'h40A00000);
      settle(4);
      `CHK("high clr", 1'b0, flg.high_clamp_alarm)
      `CHK("echo back", 32'h40A00000, echo)
      wr(`AOC_CTRL_OFS, 32'h00000021);
      wr(`AOC_REQ_OFS, 32'hC1A00000);
      settle(4);
      `CHK("low alarm", 1'b1, flg.low_clamp_alarm)
      `CHK("echo low", 32'hC1200000, echo)
      i_aoc_host.unlatch(32'h00000021, 32'h00000200);
      settle(4);
      `CHK("unlatch early", 1'b1, flg.low_clamp_alarm)
      wr(`AOC_REQ_OFS, 32'h00000000);
      settle(4);
      `CHK("low latched", 1'b1, flg.low_clamp_alarm)
      i_aoc_host.unlatch(32'h00000021, 32'h00000200);
      settle(4);
      `CHK("low unlatched", 1'b0, flg.low_clamp_alarm)
      $display("test clamp done");
   endtask

   task automatic t_ramp;
      wr(`AOC_CTRL_OFS, 32'h00000019);
      wr(`AOC_REQ_OFS, 32'h40A00000);
      settle(4);
      `CHK("ramp alarm", 1'b1, flg.ramp_rate_alarm)
      `CHK("ramping", 1'b1, drv < 32'sh00050000)
      settle(700);
      `CHK("echo ramped", 32'h40A00000, echo)
      `CHK("ramp latched", 1'b1, flg.ramp_rate_alarm)
      i_aoc_host.unlatch(32'h00000019, 32'h00000100);
      settle(4);
      `CHK("ramp unlatched", 1'b0, flg.ramp_rate_alarm)
      $display("test ramp done");
   endtask

   task automatic t_hold;
      wr(`AOC_CTRL_OFS, 32'h00000000);
      settle(4);
      `CHK("echo prog", 32'h00000000, echo)
      wr(`AOC_CTRL_OFS, 32'h00000005);
      settle(4);
      `CHK("hold on", 1'b1, flg.output_hold_flag)
      `CHK("echo held", 32'h00000000, echo)
      wr(`AOC_REQ_OFS, 32'h00000000);
      settle(4);
      `CHK("hold off", 1'b0, flg.output_hold_flag)
      wr(`AOC_REQ_OFS, 32'h40400000);
      settle(4);
      `CHK("echo after hold", 32'h40400000, echo)
      wr(`AOC_CTRL_OFS, 32'h00000003);
      wr(`AOC_REQ_OFS, 32'h40A00000);
      settle(4);
      `CHK("echo cal", 32'h40400000, echo)
      $display("test hold done");
   endtask

   task automatic t_fault;
      wr(`AOC_PROG_OFS, 32'h3F800000);
      wr(`AOC_FAULT_OFS, 32'h40000000);
      wr(`AOC_CTRL_OFS, 32'h00000040);
      i_aoc_host.set_fault(1'b1);
      settle(5);
      `CHK("fault value", 32'h40000000, echo)
      wr(`AOC_CTRL_OFS, 32'h00000000);
      settle(4);
      `CHK("prog value", 32'h3F800000, echo)
      i_aoc_host.set_fault(1'b0);
      $display("test fault done");
   endtask

   task automatic complete_run;
      $display("compared %0d, wrong %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // whole run is about 900 cycles, so this only trips on a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      $display("watchdog expired");
      complete_run;
   end

   initial begin
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_invalid;
      t_clamp;
      t_ramp;
      t_hold;
      t_fault;
      complete_run;
   end
endmodule
